// ===== hw/srstc_cfg.svh
`ifndef SRSTC_CFG_SVH
`define SRSTC_CFG_SVH
// register byte addresses on the apb slave
`define SRSTC_SYSTEM_CONTROL_ZERO_ADDR 12'h000
`define SRSTC_CAUSE_ADDR 12'h004
`define SRSTC_STATUS_ADDR 12'h008
`define SRSTC_MEMCFG_ADDR 12'h00c
// system_control_zero soft reset bit positions
`define SRSTC_SOFT_LOW_BIT 6
`define SRSTC_SOFT_HIGH_BIT 7
// reset_cause_register flag positions
`define SRSTC_F_PIN 0
`define SRSTC_F_WDOG 1
`define SRSTC_F_SOFT 2
`define SRSTC_F_ILLADDR 3
`define SRSTC_F_OSC 4
`define SRSTC_F_SUPPLY 5
`define SRSTC_F_ODD 6
`define SRSTC_NUM_SRC 7
// reset values
`define SRSTC_SYSTEM_CONTROL_ZERO_RST 8'h40
`define SRSTC_MASK_RST 4'hf
`define SRSTC_MEMTOP_RST 17'h0ffff
// timing: period and pin low time in ns, other minimum times in cycles of system_clock
`define SRSTC_CLK_NS 10
`define SRSTC_PIN_LOW_NS 80
`define SRSTC_PIN_LOW_CYC \
   ((`SRSTC_PIN_LOW_NS + `SRSTC_CLK_NS - 1) / `SRSTC_CLK_NS)
`define SRSTC_HOLD_CYC 8
`define SRSTC_START_CYC 6
// service routine address location of the reset trap entry, then base of the word-only upper half
`define SRSTC_VECTOR_ADDR 17'h08002
`define SRSTC_WORDONLY_BASE 17'h10000
`endif

// ===== hw/srstc_pkg.sv
package srstc_pkg;
   typedef enum logic [2:0] {
      SRSTC_IDLE,
      SRSTC_HOLD,
      SRSTC_INDEX,
      SRSTC_VECTOR,
      SRSTC_RELOAD,
      SRSTC_RUN
   } srstc_state_t;
endpackage

// ===== hw/srstc_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two flop level synchroniser, output reads only the second stage
module srstc_sync
#(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_r <= INIT;
         q <= INIT;
      end
      else
      begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule
`default_nettype wire

// ===== hw/srstc_top.sv
// How it works
// RQ1: seven reset causes, six internal and one from the external pin.
// RQ2: a falling edge on the reset pin starts a system reset.
// RQ3: watchdog overflow or bad watchdog key/control write raises reset.
// RQ4: soft write with low bit 0 or high bit 1 gives global reset.
// RQ5: access to an unimplemented address raises a system reset.
// RQ6: oscillator fault raises reset and sets the oscillator cause flag.
// RQ7: supply out of range is a reset source, also at power-up.
// RQ8: word access at an odd byte address is illegal and resets.
// RQ9: any reset drives the pin low for at least eight clocks.
// RQ10: reset lasts eight clocks, longer while supply, oscillator, pin bad.
// RQ11: cause register holds one flag per source, seven flags.
// RQ12: reset initialises control registers and sets all mask bits to 1.
// RQ13: after reset compute trap index, read vector 8002h, reload pipeline.
// RQ14: six clocks from reset release to first opcode fetch.
// RQ15: reset leaves ram untouched, only control bits reset.
// RQ16: outside agents hold the pin low at least one clock.
// RQ17: word has msbyte at even address, lsbyte at next odd address.
// RQ18: lower 64k byte or word access, upper 64k word only.
// RQ19: software clears cause flags after reading them.
// RQ20: pin cause flag sets whenever the pin is low, own drive included.
// RQ21: both soft reset bits written at once; high 0 low 1 only safe.
// RQ22: sources synchronised, ored into one request, flags set at once.
`timescale 1ns/1ps
`default_nettype none
`include "srstc_cfg.svh"
module srstc_top
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rst_pin_i,
   output logic rst_pin_o,
   output logic rst_pin_oe,
   input wire logic wdog_overflow,
   input wire logic wdog_bad_write,
   input wire logic osc_fault,
   input wire logic supply_bad,
   input wire logic mem_req,
   input wire logic mem_word,
   input wire logic [16:0] mem_addr,
   output logic sys_reset_n,
   output logic [3:0] int_mask,
   output logic vector_rd,
   output logic [16:0] vector_addr,
   output logic [15:0] fetch_word_addr,
   input wire logic [15:0] vector_msb_lsb,
   output logic pipe_reload,
   output logic first_fetch
);
   import srstc_pkg::*;

   localparam logic [3:0] HOLD_N = 4'(`SRSTC_HOLD_CYC);
   localparam logic [3:0] PIN_N = 4'(`SRSTC_PIN_LOW_CYC);

   srstc_state_t state_r;
   logic [3:0] hold_cnt_r;
   logic [3:0] pin_cnt_r;
   logic [2:0] start_cnt_r;
   logic [7:0] system_control_zero_r;
   logic [6:0] cause_r;
   logic [16:0] mem_top_r;
   logic [15:0] vector_r;
   logic pin_q;
   logic pin_prev_r;
   logic pin_fall;
   logic [3:0] async_q;
   logic wdog_ovf_q;
   logic wdog_wr_q;
   logic osc_q;
   logic supply_q;
   logic soft_req;
   logic addr_bad;
   logic odd_bad;
   logic [6:0] src_hit;
   logic any_req;
   logic stay_in_reset;
   logic apb_wr;
   logic apb_rd;
   logic [7:0] soft_val;

   // pin and level sources pass through the synchroniser first [RQ22]
   srstc_sync #(.W(1), .INIT(1'b1)) u_pin_sync
   (
      .pclk(pclk),
      .presetn(presetn),
      .d(rst_pin_i),
      .q(pin_q)
   );

   // one flop pair per source, so each request lags by the same two clocks
   srstc_sync #(.W(1), .INIT(1'b0)) u_wdog_ovf_sync
   (
      .pclk(pclk),
      .presetn(presetn),
      .d(wdog_overflow),
      .q(wdog_ovf_q)
   );

   srstc_sync #(.W(1), .INIT(1'b0)) u_wdog_wr_sync
   (
      .pclk(pclk),
      .presetn(presetn),
      .d(wdog_bad_write),
      .q(wdog_wr_q)
   );

   srstc_sync #(.W(1), .INIT(1'b0)) u_osc_sync
   (
      .pclk(pclk),
      .presetn(presetn),
      .d(osc_fault),
      .q(osc_q)
   );

   srstc_sync #(.W(1), .INIT(1'b0)) u_supply_sync
   (
      .pclk(pclk),
      .presetn(presetn),
      .d(supply_bad),
      .q(supply_q)
   );

   assign async_q = {supply_q, osc_q, wdog_wr_q, wdog_ovf_q}; // [RQ22]

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pin_prev_r <= 1'b1;
      else
         pin_prev_r <= pin_q;
   end

   // pin falling edge starts reset; one clock low is enough to see it
   assign pin_fall = pin_prev_r & ~pin_q; // [RQ2] [RQ16]

   assign apb_wr = psel & penable & pwrite;
   assign apb_rd = psel & penable & ~pwrite;
   assign soft_val = pwdata[7:0];

   // both bits come from one write, so a single byte lane decides [RQ21]
   assign soft_req = apb_wr & pstrb[0] & (paddr == `SRSTC_SYSTEM_CONTROL_ZERO_ADDR)
      & (~soft_val[`SRSTC_SOFT_LOW_BIT]
      | soft_val[`SRSTC_SOFT_HIGH_BIT]); // [RQ4]

   // unimplemented space lies above the configured memory top [RQ5]
   assign addr_bad = mem_req & (mem_addr > mem_top_r);
   // odd word address, or byte access in the word-only upper half
   assign odd_bad = mem_req & ((mem_word & mem_addr[0])
      | (~mem_word & (mem_addr >= `SRSTC_WORDONLY_BASE))); // [RQ8] [RQ18]

   always_comb
   begin
      src_hit = '0;
      src_hit[`SRSTC_F_PIN] = pin_fall | ~pin_q; // [RQ20]
      src_hit[`SRSTC_F_WDOG] = async_q[0] | async_q[1]; // [RQ3]
      src_hit[`SRSTC_F_SOFT] = soft_req;
      src_hit[`SRSTC_F_ILLADDR] = addr_bad;
      src_hit[`SRSTC_F_OSC] = async_q[2]; // [RQ6]
      src_hit[`SRSTC_F_SUPPLY] = async_q[3]; // [RQ7]
      src_hit[`SRSTC_F_ODD] = odd_bad;
   end

   // pin level alone must not retrigger; a pin fall, own drive included, still requests reset
   assign any_req = (|src_hit[6:1]) | pin_fall; // [RQ1] [RQ22]
   assign stay_in_reset = async_q[3] | async_q[2] | ~pin_q; // [RQ10]

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r <= SRSTC_HOLD;
         hold_cnt_r <= '0;
         start_cnt_r <= '0;
      end
      else
      begin
         case (state_r)
            SRSTC_HOLD:
            begin
               if (hold_cnt_r < HOLD_N - 4'h1 || stay_in_reset || any_req)
                  hold_cnt_r <= (any_req || stay_in_reset) ? 4'h0
                     : hold_cnt_r + 4'h1; // [RQ10]
               else
               begin
                  state_r <= SRSTC_INDEX;
                  start_cnt_r <= 3'h1;
               end
            end
            SRSTC_INDEX, SRSTC_VECTOR, SRSTC_RELOAD:
            begin
               if (any_req)
               begin
                  state_r <= SRSTC_HOLD;
                  hold_cnt_r <= '0;
               end
               else
               begin
                  start_cnt_r <= start_cnt_r + 3'h1;
                  // index, vector read, then reload, five clocks before run [RQ13]
                  if (start_cnt_r == 3'h1)
                     state_r <= SRSTC_VECTOR;
                  else if (start_cnt_r == 3'h3)
                     state_r <= SRSTC_RELOAD;
                  else if (start_cnt_r == 3'(`SRSTC_START_CYC - 1))
                     state_r <= SRSTC_RUN; // [RQ14]
               end
            end
            SRSTC_RUN:
            begin
               if (any_req)
               begin
                  state_r <= SRSTC_HOLD;
                  hold_cnt_r <= '0;
               end
               // one more count gives a single first_fetch pulse [RQ14]
               else if (start_cnt_r == 3'(`SRSTC_START_CYC))
                  start_cnt_r <= start_cnt_r + 3'h1;
            end
            default:
               state_r <= SRSTC_HOLD;
         endcase
      end
   end

   // the pin is stretched from the request, independent of the hold count
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pin_cnt_r <= PIN_N;
      else if (any_req)
         pin_cnt_r <= PIN_N; // [RQ9]
      else if (pin_cnt_r != 4'h0)
         pin_cnt_r <= pin_cnt_r - 4'h1;
   end

   assign rst_pin_o = 1'b0;
   assign rst_pin_oe = (pin_cnt_r != 4'h0); // [RQ9]
   assign sys_reset_n = (state_r != SRSTC_HOLD);
   assign vector_addr = `SRSTC_VECTOR_ADDR; // [RQ13]
   assign fetch_word_addr = vector_r;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         vector_rd <= 1'b0;
         pipe_reload <= 1'b0;
      end
      else
      begin
         vector_rd <= (state_r == SRSTC_VECTOR) && !any_req;
         pipe_reload <= (state_r == SRSTC_RELOAD) && !any_req;
      end
   end

   // fetch starts after six whole clocks of start-up, not inside the sixth
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         first_fetch <= 1'b0;
      else
         first_fetch <= (state_r == SRSTC_RUN) && !any_req
            && (start_cnt_r == 3'(`SRSTC_START_CYC)); // [RQ14]
   end

   // vector word arrives msbyte first from the even address [RQ17]
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         vector_r <= '0;
      else if (state_r == SRSTC_HOLD)
         vector_r <= '0;
      else if (vector_rd)
         vector_r <= {vector_msb_lsb[15:8], vector_msb_lsb[7:0]};
   end

   // mask bits all set while held in reset, nmi included [RQ12]
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         int_mask <= `SRSTC_MASK_RST;
      // masks close at the very edge a request is taken, not one clock later
      else if (state_r == SRSTC_HOLD || any_req)
         int_mask <= `SRSTC_MASK_RST; // [RQ12]
      else if (apb_wr && pstrb[0] && paddr == `SRSTC_STATUS_ADDR)
         int_mask <= pwdata[3:0];
   end

   // control register returns to reset value; cause flags survive [RQ15]
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         system_control_zero_r <= `SRSTC_SYSTEM_CONTROL_ZERO_RST;
      else if (state_r == SRSTC_HOLD)
         system_control_zero_r <= `SRSTC_SYSTEM_CONTROL_ZERO_RST; // [RQ15]
      else if (apb_wr && pstrb[0] && paddr == `SRSTC_SYSTEM_CONTROL_ZERO_ADDR && !soft_req)
         system_control_zero_r <= soft_val & 8'hc0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mem_top_r <= `SRSTC_MEMTOP_RST;
      else if (apb_wr && paddr == `SRSTC_MEMCFG_ADDR && state_r != SRSTC_HOLD)
         mem_top_r <= pwdata[16:0];
   end

   // write one to clear, a new cause in the same cycle wins [RQ11] [RQ19]
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cause_r <= 7'(1 << `SRSTC_F_SUPPLY); // [RQ7]
      else if (apb_wr && pstrb[0] && paddr == `SRSTC_CAUSE_ADDR)
         cause_r <= (cause_r & ~pwdata[6:0]) | src_hit; // [RQ22]
      else
         cause_r <= cause_r | src_hit; // [RQ11]
   end

   always_comb
   begin
      prdata = '0;
      pslverr = 1'b0;
      if (apb_rd)
      begin
         case (paddr)
            `SRSTC_SYSTEM_CONTROL_ZERO_ADDR: prdata = {24'h0, system_control_zero_r};
            `SRSTC_CAUSE_ADDR: prdata = {25'h0, cause_r};
            `SRSTC_STATUS_ADDR: prdata = {27'h0, sys_reset_n, int_mask};
            `SRSTC_MEMCFG_ADDR: prdata = {15'h0, mem_top_r};
            default: pslverr = 1'b1;
         endcase
      end
      else if (psel && penable)
      begin
         case (paddr)
            `SRSTC_SYSTEM_CONTROL_ZERO_ADDR, `SRSTC_CAUSE_ADDR,
            `SRSTC_STATUS_ADDR, `SRSTC_MEMCFG_ADDR: pslverr = 1'b0;
            default: pslverr = 1'b1;
         endcase
      end
   end

   assign pready = 1'b1;
endmodule
`default_nettype wire

// ===== testbench/srstc_chk_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module srstc_chk
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic rst_pin_i,
   input wire logic rst_pin_oe,
   input wire logic supply_bad,
   input wire logic mem_req,
   input wire logic mem_word,
   input wire logic [16:0] mem_addr,
   input wire logic sys_reset_n,
   input wire logic [3:0] int_mask,
   input wire logic vector_rd,
   input wire logic [16:0] vector_addr,
   input wire logic pipe_reload,
   input wire logic first_fetch
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   pin_stretch_a:
      assert property ($rose(rst_pin_oe) |-> rst_pin_oe[*8])
      else $error("reset pin released early");
   hold_len_a:
      assert property ($rose(sys_reset_n) |-> !$past(sys_reset_n, 8))
      else $error("internal reset too short");
   start_seq_a:
      assert property ($rose(sys_reset_n) |-> ##[2:4]
         (vector_rd && vector_addr == 17'h08002) ##[1:2] pipe_reload)
      else $error("start-up order wrong");
   first_fetch_a:
      assert property ($rose(sys_reset_n) |->
         ##1 !first_fetch[*5] ##1 first_fetch)
      else $error("first fetch not six cycles after release");
   mask_all_a:
      assert property (!sys_reset_n |-> int_mask == 4'hf)
      else $error("masks not set in reset");
   odd_word_a:
      assert property (mem_req && mem_word && mem_addr[0] && sys_reset_n
         |-> ##[1:3] !sys_reset_n)
      else $error("odd word access did not reset");
   word_only_a:
      assert property (mem_req && !mem_word && mem_addr[16] && sys_reset_n
         |-> ##[1:3] !sys_reset_n)
      else $error("upper byte access did not reset");
   supply_hold_a:
      assert property (supply_bad[*3] |=> !sys_reset_n && rst_pin_oe)
      else $error("reset left while supply bad");
   pin_fall_a:
      assert property ($fell(rst_pin_i) |-> ##[0:4] rst_pin_oe)
      else $error("pin fall not answered");
   cover property ($rose(sys_reset_n));
   cover property (supply_bad[*8]);
   cover property (mem_req && mem_word && mem_addr[0]);
endmodule
bind srstc_top srstc_chk i_chk (.pclk, .presetn, .rst_pin_i, .rst_pin_oe,
   .supply_bad, .mem_req, .mem_word, .mem_addr, .sys_reset_n, .int_mask,
   .vector_rd, .vector_addr, .pipe_reload, .first_fetch);
`default_nettype wire

// ===== testbench/srstc_pin_dev.sv
`timescale 1ns/1ps
`default_nettype none
// outside device on the shared reset line, with the pull-up
module srstc_pin_dev
(
   input wire logic pclk,
   input wire logic pull_req,
   input wire logic dut_oe,
   input wire logic dut_o,
   output logic pin
);
   logic [1:0] low_r = 2'h0;
   always_ff @(posedge pclk)
   begin
      // at least one full clock low, so the pulse is always seen
      low_r <= pull_req ? 2'h2
         : (low_r == 2'h0 ? 2'h0 : low_r - 2'h1);
   end
   assign pin = !((dut_oe && !dut_o) || low_r != 2'h0);
endmodule
`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "srstc_cfg.svh"
module tb;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, pull_req = 1'b0, mem_req = 1'b0, mem_word = 1'b0;
   logic wdog_overflow = 1'b0, wdog_bad_write = 1'b0;
   logic osc_fault = 1'b0, supply_bad = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [16:0] mem_addr = 17'h00000;
   logic pready, pslverr, rst_pin_i, rst_pin_o, rst_pin_oe, err, sys_reset_n;
   logic [15:0] fetch_word_addr;
   // a byte access at the word-only base also lies above the memory top
   logic [6:0] exp_c [11] = '{7'h01, 7'h02, 7'h02, 7'h04, 7'h04, 7'h04,
      7'h08, 7'h10, 7'h20, 7'h40, 7'h48};
   int errors = 0, n_compared = 0;
   srstc_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr, .rst_pin_i,
      .rst_pin_o, .rst_pin_oe, .wdog_overflow, .wdog_bad_write, .osc_fault,
      .supply_bad, .mem_req, .mem_word, .mem_addr, .sys_reset_n,
      .int_mask(), .vector_rd(), .vector_addr(), .fetch_word_addr,
      .vector_msb_lsb(16'h1234), .pipe_reload(), .first_fetch());
   srstc_pin_dev i_pin (.pclk, .pull_req, .dut_oe(rst_pin_oe),
      .dut_o(rst_pin_o), .pin(rst_pin_i));
   initial
   begin
      forever #5 pclk = ~pclk;
   end
   task automatic end_of_test();
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20)
      begin
         @(posedge pclk);
         n++;
      end
      if (n == 20)
      begin
         errors++;
         end_of_test();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // one whole reset, then the fixed start-up before software runs
   task automatic wait_rst();
      int n;
      chk(32'(sys_reset_n), 32'h0);
      n = 0;
      while (sys_reset_n !== 1'b1 && n < 300)
      begin
         @(posedge pclk);
         n++;
      end
      if (n == 300)
      begin
         errors++;
         end_of_test();
      end
      repeat (8) @(posedge pclk);
      chk(32'(fetch_word_addr), 32'h1234);
   endtask
   task automatic fire(input int k);
      case (k)
         0: pull_req <= 1'b1;
         1: wdog_overflow <= 1'b1;
         2: wdog_bad_write <= 1'b1;
         3, 4, 5:
            apb(1'b1, `SRSTC_SYSTEM_CONTROL_ZERO_ADDR,
               {24'h0, k > 3, k == 5, 6'h0});
         7: osc_fault <= 1'b1;
         8: supply_bad <= 1'b1;
         default:
         begin
            mem_req <= 1'b1;
            mem_word <= k != 10;
            mem_addr <= k == 6 ? 17'h1fffe : (k == 9 ? 17'h00101 : 17'h10000);
         end
      endcase
      repeat (k == 8 ? 30 : 5) @(posedge pclk);
      if (k == 8)
         chk(32'(sys_reset_n), 32'h0);
      pull_req <= 1'b0;
      wdog_overflow <= 1'b0;
      wdog_bad_write <= 1'b0;
      osc_fault <= 1'b0;
      supply_bad <= 1'b0;
      mem_req <= 1'b0;
   endtask
   initial
   begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      wait_rst();
      apb(1'b0, `SRSTC_CAUSE_ADDR, 32'h0);
      chk(rd, 32'h21);
      apb(1'b0, 12'h010, 32'h0);
      chk(32'(err), 32'h1);
      apb(1'b0, `SRSTC_MEMCFG_ADDR, 32'h0);
      chk(rd, 32'h0ffff);
      apb(1'b1, `SRSTC_SYSTEM_CONTROL_ZERO_ADDR, 32'h40);
      apb(1'b0, `SRSTC_SYSTEM_CONTROL_ZERO_ADDR, 32'h0);
      chk(rd, 32'h40);
      mem_req <= 1'b1;
      mem_word <= 1'b1;
      mem_addr <= 17'h00100;
      @(posedge pclk);
      mem_word <= 1'b0;
      mem_addr <= 17'h00101;
      @(posedge pclk);
      mem_req <= 1'b0;
      repeat (6) @(posedge pclk);
      chk(32'(sys_reset_n), 32'h1);
      for (int k = 0; k < 11; k++)
      begin
         apb(1'b1, `SRSTC_STATUS_ADDR, 32'h0);
         apb(1'b1, `SRSTC_CAUSE_ADDR, 32'h7f);
         fire(k);
         wait_rst();
         apb(1'b0, `SRSTC_CAUSE_ADDR, 32'h0);
         chk(rd, {25'h0, exp_c[k] | 7'h01});
         apb(1'b0, `SRSTC_STATUS_ADDR, 32'h0);
         chk(rd, 32'h1f);
      end
      end_of_test();
   end
endmodule
`default_nettype wire
